// file: inc/audio_serial_pkg.sv
package audio_serial_pkg;
    // register byte offsets
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h00;
    localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h04;
    localparam logic [ADDR_W-1:0] DIVIDER_OFFSET = 8'h30;
    localparam logic [ADDR_W-1:0] DATA_PORT_OFFSET = 8'h34;

    // reset values
    localparam logic [3:0] DIVIDER_RESET = 4'h3;
    localparam logic [19:0] CTRL_RESET = 20'h00000;

    // control field positions
    localparam int ENABLE_POS = 0;
    localparam int MODE_LSB = 1;
    localparam int WORD_LEN_LSB = 3;
    localparam int OUT_SIZE_LSB = 6;
    localparam int IN_SIZE_LSB = 9;
    localparam int XMIT_SLOT_LSB = 12;
    localparam int RECV_SLOT_LSB = 16;

    // frame geometry
    localparam logic [4:0] TAG_LAST_BIT = 5'h0F;
    localparam logic [4:0] AC_SLOT_LAST_BIT = 5'h13;
    localparam logic [4:0] WORD_LAST_BIT = 5'h1F;
    localparam logic [4:0] WORD_DATA_LAST = 5'h17;
    localparam logic [3:0] AC_LAST_SLOT = 4'hC;
    localparam logic [3:0] STEREO_LAST_SLOT = 4'h1;

    typedef enum logic [1:0] {
        MODE_ACLINK = 2'h0,
        MODE_I2S = 2'h1,
        MODE_MSBJ = 2'h2
    } link_mode_t;

    typedef enum logic [2:0] {
        SIZE_8 = 3'h0,
        SIZE_16 = 3'h1,
        SIZE_18 = 3'h2,
        SIZE_20 = 3'h3,
        SIZE_24 = 3'h4
    } sample_size_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic bitClk;
        logic frameSync;
        logic serialOut;
    } serial_pins_t;

    // number of valid bits for a size code; unknown codes fall back to 16
    function automatic logic [4:0] sample_bits(input logic [2:0] code);
        case (code)
            SIZE_8: sample_bits = 5'h08;
            SIZE_18: sample_bits = 5'h12;
            SIZE_20: sample_bits = 5'h14;
            SIZE_24: sample_bits = 5'h18;
            default: sample_bits = 5'h10;
        endcase
    endfunction
endpackage

// file: verilog/sample_fifo.sv
`timescale 1ns/1ps
module sample_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic pushValid,
    output logic pushReady,
    input wire logic [WIDTH-1:0] pushData,
    output logic popValid,
    input wire logic popReady,
    output logic [WIDTH-1:0] popData,
    output logic [$clog2(DEPTH):0] level
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam logic [PTR_W:0] FULL_LEVEL = (PTR_W+1)'(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PTR_W-1:0] wrPtr_q;
    logic [PTR_W-1:0] rdPtr_q;
    logic [PTR_W:0] level_q;
    wire doPush = pushValid && pushReady;
    wire doPop = popValid && popReady;

    // honest flags straight from the level count
    assign pushReady = level_q != FULL_LEVEL;
    assign popValid = level_q != '0;
    assign popData = mem_q[rdPtr_q];
    assign level = level_q;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            level_q <= '0;
        end else begin
            if (doPush) wrPtr_q <= (wrPtr_q == PTR_W'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
            if (doPop) rdPtr_q <= (rdPtr_q == PTR_W'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
            level_q <= level_q + (PTR_W+1)'(doPush) - (PTR_W+1)'(doPop);
        end
    end

    // storage has no reset; contents are only read behind popValid
    always_ff @(posedge sys_clk) begin
        if (doPush) mem_q[wrPtr_q] <= pushData;
    end

    level_bound_a: assert property (@(posedge sys_clk) disable iff (rst) level_q <= FULL_LEVEL)
        else $error("fifo level above depth");
    push_counts_a: assert property (@(posedge sys_clk) disable iff (rst)
        doPush && !doPop |=> level_q == $past(level_q) + 1'b1)
        else $error("push did not raise the level by one");
endmodule

// file: verilog/serial_audio_clock_fifo_port.sv
`timescale 1ns/1ps
module serial_audio_clock_fifo_port #(
    parameter int FIFO_DEPTH = 16
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire audio_serial_pkg::reg_req_t busReq,
    output logic [31:0] readData,
    output audio_serial_pkg::serial_pins_t pins,
    input wire logic serialIn
);
    localparam int LVL_W = $clog2(FIFO_DEPTH) + 1;

    logic [19:0] ctrl_q;
    logic [3:0] divider_q;
    logic [31:0] readData_q;
    logic [3:0] divCnt_q;
    logic bitClk_q;
    logic started_q;
    logic [3:0] slot_q;
    logic [4:0] bit_q;
    logic [31:0] txShift_q;
    logic [31:0] rxShift_q;
    logic serOut_q;
    logic sync_q;
    logic rxPush_q;
    logic [23:0] rxSample_q;

    // control fields
    wire enable = ctrl_q[audio_serial_pkg::ENABLE_POS];
    wire audio_serial_pkg::link_mode_t mode = audio_serial_pkg::link_mode_t'(ctrl_q[audio_serial_pkg::MODE_LSB +: 2]);
    wire [2:0] wordLength = ctrl_q[audio_serial_pkg::WORD_LEN_LSB +: 3];
    wire [2:0] outSize = ctrl_q[audio_serial_pkg::OUT_SIZE_LSB +: 3];
    wire [2:0] inSize = ctrl_q[audio_serial_pkg::IN_SIZE_LSB +: 3];
    wire [3:0] xmitSlot = ctrl_q[audio_serial_pkg::XMIT_SLOT_LSB +: 4];
    wire [3:0] recvSlot = ctrl_q[audio_serial_pkg::RECV_SLOT_LSB +: 4];
    wire acLink = mode == audio_serial_pkg::MODE_ACLINK;

    // sample width per direction
    wire [4:0] txBits = audio_serial_pkg::sample_bits(acLink ? outSize : wordLength);
    wire [4:0] rxBits = audio_serial_pkg::sample_bits(acLink ? inSize : wordLength);

    // register bus decode
    wire wrCtrl = busReq.wr && busReq.addr == audio_serial_pkg::CTRL_OFFSET;
    wire wrDivider = busReq.wr && busReq.addr == audio_serial_pkg::DIVIDER_OFFSET;
    wire wrData = busReq.wr && busReq.addr == audio_serial_pkg::DATA_PORT_OFFSET;
    wire rdData = busReq.rd && busReq.addr == audio_serial_pkg::DATA_PORT_OFFSET;

    // fifo wiring
    logic txReady;
    logic txValid;
    logic [23:0] txData;
    logic [LVL_W-1:0] txLevel;
    logic rxReady;
    logic rxValid;
    logic [23:0] rxData;
    logic [LVL_W-1:0] rxLevel;

    // divider: last count of each half period is (ratio minus one) shifted down, ratio always even
    wire [3:0] halfLast = {1'b0, divider_q[3:1]};
    wire tick = enable && divCnt_q == halfLast;
    wire fallPulse = tick && bitClk_q;
    wire risePulse = tick && !bitClk_q;

    // position of the last bit of the current slot: tag, other AC-link slot or stereo word
    function automatic logic [4:0] slot_last_bit(input logic ac, input logic [3:0] slot);
        if (!ac) begin
            slot_last_bit = audio_serial_pkg::WORD_LAST_BIT;
        end else if (slot == 4'h0) begin
            slot_last_bit = audio_serial_pkg::TAG_LAST_BIT;
        end else begin
            slot_last_bit = audio_serial_pkg::AC_SLOT_LAST_BIT;
        end
    endfunction

    wire [4:0] curLast = slot_last_bit(acLink, slot_q);
    wire [3:0] lastSlot = acLink ? audio_serial_pkg::AC_LAST_SLOT : audio_serial_pkg::STEREO_LAST_SLOT;
    wire slotEnd = bit_q == curLast;
    wire [4:0] advBit = (!started_q || slotEnd) ? 5'h00 : bit_q + 5'h01;
    wire [3:0] advSlot = !started_q ? 4'h0 : !slotEnd ? slot_q : (slot_q == lastSlot) ? 4'h0 : slot_q + 4'h1;

    // slot carries a sample: both phases in stereo modes, chosen pair in AC-link
    wire txSlotHit = !acLink || advSlot == xmitSlot || advSlot == xmitSlot + 4'h1;
    wire rxSlotHit = !acLink || slot_q == recvSlot || slot_q == recvSlot + 4'h1;
    wire txLoad = fallPulse && advBit == 5'h00 && txSlotHit;

    // left-align the sample in a 32-bit word; an AC-link slot uses its top 20 bits
    wire [4:0] txShiftAmt = 5'h18 - txBits;
    wire [31:0] txAligned = {txData, 8'h00} << txShiftAmt;
    wire [31:0] loadWord = (txLoad && txValid) ? txAligned : 32'h00000000;

    // frame sync for the bit about to be driven
    logic nextSync;
    always_comb begin
        case (mode)
            audio_serial_pkg::MODE_I2S: nextSync = (advSlot == 4'h0) ? advBit == 5'h1F : advBit != 5'h1F;
            audio_serial_pkg::MODE_MSBJ: nextSync = advSlot == 4'h0;
            default: nextSync = advSlot == 4'h0;
        endcase
    end

    // receive word, always left-aligned; AC-link gets zeros under its 20 bits
    wire [31:0] rxWord = acLink ? {rxShift_q[18:0], serialIn, 12'h000} : {rxShift_q[30:0], serialIn};
    wire [4:0] rxShiftAmt = 5'h18 - rxBits;
    wire [23:0] rxExtract = rxWord[31:8] >> rxShiftAmt;

    // register read mux; reserved bits read as zero
    logic [31:0] readMux;
    always_comb begin
        if (busReq.addr == audio_serial_pkg::CTRL_OFFSET) begin
            readMux = {12'h000, ctrl_q};
        end else if (busReq.addr == audio_serial_pkg::STATUS_OFFSET) begin
            readMux = 32'h00000000;
            readMux[7:0] = 8'(txLevel);
            readMux[15:8] = 8'(rxLevel);
            readMux[16] = !txReady;
            readMux[17] = rxValid;
            readMux[18] = started_q;
        end else if (busReq.addr == audio_serial_pkg::DIVIDER_OFFSET) begin
            readMux = {28'h0000000, divider_q};
        end else if (busReq.addr == audio_serial_pkg::DATA_PORT_OFFSET) begin
            readMux = {8'h00, rxValid ? rxData : 24'h000000};
        end else begin
            readMux = 32'h00000000;
        end
    end

    sample_fifo #(.WIDTH(24), .DEPTH(FIFO_DEPTH)) txFifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .pushValid(wrData),
        .pushReady(txReady),
        .pushData(busReq.wdata[23:0]),
        .popValid(txValid),
        .popReady(txLoad),
        .popData(txData),
        .level(txLevel)
    );

    sample_fifo #(.WIDTH(24), .DEPTH(FIFO_DEPTH)) rxFifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .pushValid(rxPush_q),
        .pushReady(rxReady),
        .pushData(rxSample_q),
        .popValid(rxValid),
        .popReady(rdData),
        .popData(rxData),
        .level(rxLevel)
    );

    // registers; writes to reserved bits simply go nowhere
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= audio_serial_pkg::CTRL_RESET;
            divider_q <= audio_serial_pkg::DIVIDER_RESET;
            readData_q <= 32'h00000000;
        end else begin
            if (wrCtrl) ctrl_q <= busReq.wdata[19:0];
            if (wrDivider) divider_q <= {busReq.wdata[3:1], 1'b1};
            readData_q <= busReq.rd ? readMux : 32'h00000000;
        end
    end

    // bit clock generator, idles high so the first edge is a fall
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            divCnt_q <= 4'h0;
            bitClk_q <= 1'b1;
        end else if (!enable) begin
            divCnt_q <= 4'h0;
            bitClk_q <= 1'b1;
        end else begin
            divCnt_q <= tick ? 4'h0 : divCnt_q + 4'h1;
            bitClk_q <= tick ? !bitClk_q : bitClk_q;
        end
    end

    // frame counters and transmit side, moved only on falling bit clock
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            started_q <= 1'b0;
            slot_q <= 4'h0;
            bit_q <= 5'h00;
            txShift_q <= 32'h00000000;
            serOut_q <= 1'b0;
            sync_q <= 1'b0;
        end else if (!enable) begin
            started_q <= 1'b0;
            serOut_q <= 1'b0;
            sync_q <= 1'b0;
        end else if (fallPulse) begin
            started_q <= 1'b1;
            slot_q <= advSlot;
            bit_q <= advBit;
            sync_q <= nextSync;
            serOut_q <= (advBit == 5'h00) ? loadWord[31] : txShift_q[31];
            txShift_q <= (advBit == 5'h00) ? {loadWord[30:0], 1'b0} : {txShift_q[30:0], 1'b0};
        end
    end

    // receive side samples on rising bit clock; overrun drops the sample
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rxShift_q <= 32'h00000000;
            rxPush_q <= 1'b0;
            rxSample_q <= 24'h000000;
        end else begin
            rxPush_q <= risePulse && started_q && slotEnd && rxSlotHit && rxReady;
            if (risePulse && started_q) begin
                rxShift_q <= {rxShift_q[30:0], serialIn};
                rxSample_q <= rxExtract;
            end
        end
    end

    assign readData = readData_q;
    assign pins = '{bitClk: bitClk_q, frameSync: sync_q, serialOut: serOut_q};

    sequence divider_read_s;
        busReq.rd && busReq.addr == audio_serial_pkg::DIVIDER_OFFSET;
    endsequence
    sequence port_read_s;
        busReq.rd && busReq.addr == audio_serial_pkg::DATA_PORT_OFFSET;
    endsequence
    sequence frame_last_s;
        fallPulse && started_q && !acLink && slot_q == 4'h1 && bit_q == 5'h1F;
    endsequence

    divider_odd_value_a: assert property (@(posedge sys_clk) disable iff (rst) divider_q[0])
        else $error("divider value lost its forced low bit");
    divider_reserved_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
        divider_read_s |=> readData[31:4] == 28'h0000000 && readData[3:0] == $past(divider_q))
        else $error("divider read shows wrong bits");
    port_reserved_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
        port_read_s |=> readData[31:24] == 8'h00)
        else $error("data port upper bits not zero");
    frame_wraps_a: assert property (@(posedge sys_clk) disable iff (rst)
        frame_last_s |=> slot_q == 4'h0 && bit_q == 5'h00)
        else $error("stereo frame did not wrap after 64 bits");
    i2s_sync_level_a: assert property (@(posedge sys_clk) disable iff (rst)
        mode == audio_serial_pkg::MODE_I2S && started_q && bit_q != 5'h1F && !$rose(started_q)
        |-> sync_q == (slot_q == 4'h1))
        else $error("i2s sync wrong for the phase");
    msbj_sync_level_a: assert property (@(posedge sys_clk) disable iff (rst)
        mode == audio_serial_pkg::MODE_MSBJ && started_q && !$rose(started_q) |-> sync_q == (slot_q == 4'h0))
        else $error("msb-justified sync wrong for the phase");
    pad_bits_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
        fallPulse && !acLink && advBit > audio_serial_pkg::WORD_DATA_LAST |=> !serOut_q)
        else $error("padding bit driven high");
    ac_slot_bound_a: assert property (@(posedge sys_clk) disable iff (rst)
        acLink && started_q |-> bit_q <= audio_serial_pkg::AC_SLOT_LAST_BIT)
        else $error("ac-link slot longer than 20 bits");
    // a ratio of two legally rises one cycle after the fall, so only longer ratios are held to this
    half_period_a: assert property (@(posedge sys_clk) disable iff (rst)
        fallPulse && halfLast != 4'h0 |=> !risePulse)
        else $error("bit clock rose right after falling");
endmodule

// file: tb/codec_model.sv
`timescale 1ns/1ps
module codec_model (
    input wire logic rst,
    input wire logic bitClk,
    input wire logic frameSync,
    input wire logic serialOut,
    input wire logic msbMode,
    input wire logic [63:0] txWord,
    output logic serialIn,
    output logic [63:0] frameWord,
    output int frameCount
);
    logic [63:0] syncHist_q;
    logic [63:0] dataHist_q;
    logic [5:0] bitPos_q;
    logic aligned_q;

    // a frame ends when the last 64 sync samples show one whole frame of the chosen format
    wire logic [63:0] syncNext = {syncHist_q[62:0], frameSync};
    wire logic [63:0] dataNext = {dataHist_q[62:0], serialOut};
    wire logic frameEnd = msbMode ? (syncNext === 64'hFFFFFFFF00000000) : (syncNext === 64'h00000001FFFFFFFE);

    // capture on the rising edge of the bit clock; this codec takes its clocks from the port, never makes them
    always_ff @(posedge bitClk or posedge rst) begin
        if (rst) begin
            syncHist_q <= '0;
            dataHist_q <= '0;
            bitPos_q <= '0;
            aligned_q <= 1'b0;
            frameWord <= '0;
            frameCount <= 0;
        end else begin
            syncHist_q <= syncNext;
            dataHist_q <= dataNext;
            bitPos_q <= frameEnd ? 6'h00 : bitPos_q + 6'h01; // wraps with the 64-bit frame
            if (frameEnd) begin
                frameWord <= dataNext;
                frameCount <= frameCount + 1;
                aligned_q <= 1'b1;
            end
        end
    end

    // drive on the falling edge; toggling before alignment so stale data never looks valid
    always_ff @(negedge bitClk or posedge rst) begin
        if (rst) begin
            serialIn <= 1'b0;
        end else begin
            serialIn <= aligned_q ? txWord[6'h3F - bitPos_q] : ~serialIn;
        end
    end
endmodule

// file: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    audio_serial_pkg::reg_req_t busReq = '0;
    logic [31:0] readData;
    audio_serial_pkg::serial_pins_t pins;
    logic serialIn;
    logic msbMode = 1'b0;
    logic [63:0] txWord = '0;
    logic [63:0] frameWord;
    int frameCount;
    int mismatches = 0;
    int checks = 0;
    logic [31:0] rdVal;

    serial_audio_clock_fifo_port #(.FIFO_DEPTH(16)) DUT (.sys_clk(sys_clk), .rst(rst), .busReq(busReq),
        .readData(readData), .pins(pins), .serialIn(serialIn));
    codec_model partner (.rst(rst), .bitClk(pins.bitClk), .frameSync(pins.frameSync), .serialOut(pins.serialOut),
        .msbMode(msbMode), .txWord(txWord), .serialIn(serialIn), .frameWord(frameWord), .frameCount(frameCount));

    // 25 MHz system clock
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // full reset also clears both fifos and the codec alignment
    task automatic do_reset();
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
    endtask

    task automatic bus_write(input logic [7:0] addr, input logic [31:0] data);
        @(posedge sys_clk);
        busReq.addr <= addr;
        busReq.wdata <= data;
        busReq.wr <= 1'b1;
        @(posedge sys_clk);
        busReq.wr <= 1'b0;
    endtask

    task automatic bus_read(input logic [7:0] addr, output logic [31:0] data);
        @(posedge sys_clk);
        busReq.addr <= addr;
        busReq.rd <= 1'b1;
        @(posedge sys_clk);
        busReq.rd <= 1'b0;
        #1;
        data = readData;
    endtask

    // one stereo frame out, one looped-in frame back, plus bit clock timing
    task automatic run_stereo(input logic [1:0] mode, input logic [2:0] size, input int bits, input logic [31:0] divW,
        input int ratio, input logic [31:0] left, input logic [31:0] right, input logic [63:0] rxW);
        logic [31:0] mask;
        logic [63:0] expWord;
        int startCount;
        int n;
        int hi;
        mask = (32'h1 << bits) - 32'h1;
        expWord = {(left & mask) << (32 - bits), (right & mask) << (32 - bits)};
        do_reset();
        msbMode <= (mode == audio_serial_pkg::MODE_MSBJ);
        txWord <= rxW;
        bus_write(audio_serial_pkg::DIVIDER_OFFSET, divW);
        bus_read(audio_serial_pkg::DIVIDER_OFFSET, rdVal);
        check(rdVal, ratio - 1);
        bus_write(audio_serial_pkg::DATA_PORT_OFFSET, left);
        bus_write(audio_serial_pkg::DATA_PORT_OFFSET, right);
        startCount = frameCount;
        bus_write(audio_serial_pkg::CTRL_OFFSET, 32'h1 | (32'(mode) << audio_serial_pkg::MODE_LSB)
            | (32'(size) << audio_serial_pkg::WORD_LEN_LSB));
        // period between falls and high time, in system clocks
        @(negedge pins.bitClk);
        hi = 0;
        for (n = 1; n < 64; n++) begin
            @(posedge sys_clk);
            #1;
            if (pins.bitClk === 1'b1) begin
                hi++;
            end else if (hi > 0) begin
                break;
            end
        end
        check(n, ratio);
        check(hi, ratio / 2);
        for (n = 0; n < 3000 && frameCount == startCount; n++) begin
            @(posedge sys_clk);
        end
        if (frameCount == startCount) begin
            mismatches++;
            complete_run();
        end
        check(frameWord, expWord);
        // poll the receive level first; the first frame back is unaligned filler
        for (n = 0; n < 400; n++) begin
            bus_read(audio_serial_pkg::STATUS_OFFSET, rdVal);
            if (rdVal[15:8] >= 8'h04) begin
                break;
            end
        end
        if (n == 400) begin
            mismatches++;
            complete_run();
        end
        bus_read(audio_serial_pkg::DATA_PORT_OFFSET, rdVal);
        bus_read(audio_serial_pkg::DATA_PORT_OFFSET, rdVal);
        bus_read(audio_serial_pkg::DATA_PORT_OFFSET, rdVal);
        check(rdVal, rxW[63:32] >> (32 - bits));
        bus_read(audio_serial_pkg::DATA_PORT_OFFSET, rdVal);
        check(rdVal, rxW[31:0] >> (32 - bits));
        $display("stereo test done: mode %0d, %0d bits", mode, bits);
    endtask

    // main sequence
    initial begin
        do_reset();
        bus_read(audio_serial_pkg::DIVIDER_OFFSET, rdVal);
        check(rdVal, 32'h00000003);
        bus_write(audio_serial_pkg::DIVIDER_OFFSET, 32'hFFFFFFF0);
        bus_read(audio_serial_pkg::DIVIDER_OFFSET, rdVal);
        check(rdVal, 32'h00000001);
        bus_read(8'h7C, rdVal);
        check(rdVal, 32'h00000000);
        bus_read(audio_serial_pkg::DATA_PORT_OFFSET, rdVal);
        check(rdVal, 32'h00000000);
        @(posedge sys_clk);
        #1;
        check(readData, 32'h00000000);
        check(pins.bitClk, 1'b1);
        $display("register test done");
        run_stereo(audio_serial_pkg::MODE_I2S, audio_serial_pkg::SIZE_24, 24, 32'h00000006, 8,
            32'hFF123456, 32'h00A5C3E1, 64'h89ABCDEF76543210);
        run_stereo(audio_serial_pkg::MODE_MSBJ, audio_serial_pkg::SIZE_16, 16, 32'h00000003, 4,
            32'h00ABCDEF, 32'h00001234, 64'hFEDCBA9801234567);
        run_stereo(audio_serial_pkg::MODE_I2S, audio_serial_pkg::SIZE_20, 20, 32'h00000001, 2,
            32'h00F0F0F5, 32'h0008ACE1, 64'hC3C3C3C35A5A5A5A);
        run_stereo(audio_serial_pkg::MODE_MSBJ, audio_serial_pkg::SIZE_18, 18, 32'h00000003, 4,
            32'h0003FFFF, 32'h00025555, 64'h123456789ABCDEF0);
        run_stereo(audio_serial_pkg::MODE_I2S, audio_serial_pkg::SIZE_8, 8, 32'h00000003, 4,
            32'h000000A7, 32'h0000FF5C, 64'hE1000000B7000000);
        complete_run();
    end

    // hang guard
    initial begin
        #2400000;
        mismatches++;
        complete_run();
    end
endmodule
